// ---- src/sxs_exec.sv ----
/*
  Execution unit for literal/register subtraction, nibble exchange, xor,
  direction register load and halt, with its state behind an AXI4-Lite slave.
  Assumes a single clock, a synchronous active-low reset and a well-behaved
  AXI4-Lite master.
*/
// Contract
// - Literal-minus-acc puts literal minus accumulator into the accumulator.
// - Literal subtraction sets carry unless the accumulator exceeds the literal; digit carry likewise on nibbles.
// - Literal subtraction clears digit carry when the acc low nibble exceeds the literal low nibble, else sets it.
// - Halt stops the oscillator and enters the halt state.
// - Halt clears the watchdog counter and its prescaler.
// - Halt clears the active-low power-down bit and sets the active-low time-out bit.
// - Reg-minus-acc subtracts the accumulator from file register 0 to 127.
// - Register instructions write the accumulator when d is 0, the file register when d is 1.
// - Register subtraction sets carry unless acc exceeds the register; digit carry on the low nibbles.
// - Subtract with borrow also takes away the inverted carry and updates carry, digit carry and zero.
// - Nibble exchange swaps the register's nibbles into the destination and leaves flags alone.
// - Xor-literal xors the accumulator with the literal into the accumulator, touching only zero.
// - Xor-register xors acc with the file register into the destination, touching only zero.
// - Load-direction copies the accumulator into port A, B or C direction for operand 5, 6 or 7.
`timescale 1ns/10ps
module sxs_exec #(
  parameter int unsigned PRESC_W = 8
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [11:0]   awaddr,
  input  wire logic [2:0]    awprot,
  input  wire logic          awvalid,
  output      logic          awready,
  input  wire logic [31:0]   wdata,
  input  wire logic [3:0]    wstrb,
  input  wire logic          wvalid,
  output      logic          wready,
  output      logic [1:0]    bresp,
  output      logic          bvalid,
  input  wire logic          bready,
  input  wire logic [11:0]   araddr,
  input  wire logic [2:0]    arprot,
  input  wire logic          arvalid,
  output      logic          arready,
  output      logic [31:0]   rdata,
  output      logic [1:0]    rresp,
  output      logic          rvalid,
  input  wire logic          rready,
  output      logic          osc_run,
  output      logic          halted,
  output      logic [7:0]    port_a_direction,
  output      logic [7:0]    port_b_direction,
  output      logic [7:0]    port_c_direction,
  output      logic [7:0]    watchdog_counter
);

  logic                      aw_full_r;
  logic                      w_full_r;
  logic [11:0]               aw_addr_r;
  logic [31:0]               w_data_r;
  logic [3:0]                w_strb_r;
  logic                      bvalid_r;
  logic [1:0]                bresp_r;
  logic                      rvalid_r;
  logic [31:0]               rdata_r;
  logic [1:0]                rresp_r;
  sxs_pkg::sxs_cmd_s         cmd_r;
  sxs_pkg::sxs_flags_s       flags_r;
  logic [7:0]                acc_r;
  logic [7:0]                dir_a_r;
  logic [7:0]                dir_b_r;
  logic [7:0]                dir_c_r;
  logic [7:0]                wdog_r;
  logic [PRESC_W-1:0]        presc_r;
  logic [7:0]                file_mem [sxs_pkg::FILE_DEPTH];

  // Write path: address and data are taken in either order, then committed
  assign awready = !aw_full_r;
  assign wready  = !w_full_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  wire   commit  = aw_full_r && w_full_r && !bvalid_r;

  wire   w_aligned  = (aw_addr_r[1:0] == 2'h0);
  wire   w_file     = w_aligned && (aw_addr_r[11:9] == sxs_pkg::FILE_PAGE);
  wire   w_cmd      = w_aligned && (aw_addr_r == sxs_pkg::OFF_CMD);
  wire   w_acc      = w_aligned && (aw_addr_r == sxs_pkg::OFF_ACC);
  wire   w_status   = w_aligned && (aw_addr_r == sxs_pkg::OFF_STATUS);
  wire   w_ro       = w_aligned && (aw_addr_r == sxs_pkg::OFF_DIR_A || aw_addr_r == sxs_pkg::OFF_DIR_B ||
                                    aw_addr_r == sxs_pkg::OFF_DIR_C || aw_addr_r == sxs_pkg::OFF_WDOG);
  wire   w_mapped   = w_file || w_cmd || w_acc || w_status || w_ro;
  wire   w_lane0    = commit && w_strb_r[0];

  // Byte lanes merged into the command word
  wire [31:0] cmd_merge = {w_strb_r[3] ? w_data_r[31:24] : cmd_r[31:24],
                           w_strb_r[2] ? w_data_r[23:16] : cmd_r[23:16],
                           w_strb_r[1] ? w_data_r[15:8]  : cmd_r[15:8],
                           w_strb_r[0] ? w_data_r[7:0]   : cmd_r[7:0]};
  sxs_pkg::sxs_cmd_s cmd_v;
  assign cmd_v = sxs_pkg::sxs_cmd_s'(cmd_merge);

  // A halted core ignores commands until software wakes it
  wire   exec_go   = commit && w_cmd && (w_strb_r != 4'h0) && !flags_r.halted;
  wire   op_lit    = (cmd_v.op == sxs_pkg::OP_LIT_SUB);
  wire   op_sub    = (cmd_v.op == sxs_pkg::OP_REG_SUB);
  wire   op_subb   = (cmd_v.op == sxs_pkg::OP_REG_SUB_B);
  wire   op_nib    = (cmd_v.op == sxs_pkg::OP_NIBBLE_EXCH);
  wire   op_xorl   = (cmd_v.op == sxs_pkg::OP_XOR_LIT);
  wire   op_xorr   = (cmd_v.op == sxs_pkg::OP_XOR_REG);
  wire   op_dir    = (cmd_v.op == sxs_pkg::OP_LOAD_DIR);
  wire   op_halt   = (cmd_v.op == sxs_pkg::OP_HALT);
  wire   is_sub    = op_lit || op_sub || op_subb;
  wire   is_xor    = op_xorl || op_xorr;
  wire   is_reg    = op_sub || op_subb || op_nib || op_xorr;

  wire [7:0] freg_v  = file_mem[cmd_v.f];
  wire [7:0] lit_v   = cmd_v.lit;
  // Subtraction as a + ~acc + carry-in; carry-out is the inverted borrow
  wire [7:0] sub_a   = op_lit ? lit_v : freg_v;
  wire       sub_cin = op_subb ? flags_r.c : 1'b1;
  wire [8:0] sub_sum = {1'b0, sub_a} + {1'b0, ~acc_r} + {8'h00, sub_cin};
  wire [4:0] nib_sum = {1'b0, sub_a[3:0]} + {1'b0, ~acc_r[3:0]} + {4'h0, sub_cin};
  wire [7:0] xor_res = acc_r ^ (op_xorl ? lit_v : freg_v);
  wire [7:0] swp_res = {freg_v[3:0], freg_v[7:4]};
  wire [7:0] result  = is_sub ? sub_sum[7:0] : (is_xor ? xor_res : swp_res);
  wire       res_zero = (result == 8'h00);

  // Destination select: literal ops always hit the accumulator
  wire   to_acc   = exec_go && (op_lit || op_xorl || (is_reg && !cmd_v.d));
  wire   to_file  = exec_go && is_reg && cmd_v.d;
  wire   upd_cdz  = exec_go && is_sub;
  wire   upd_z    = exec_go && (is_sub || is_xor);
  wire   do_halt  = exec_go && op_halt;
  wire   do_dir   = exec_go && op_dir;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      aw_addr_r <= 12'h000;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= sxs_pkg::RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_full_r <= 1'b1;
        aw_addr_r <= awaddr;
      end
      else if (commit)
        aw_full_r <= 1'b0;
      if (wvalid && wready)
      begin
        w_full_r <= 1'b1;
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end
      else if (commit)
        w_full_r <= 1'b0;
      if (commit)
      begin
        bvalid_r <= 1'b1;
        bresp_r  <= w_mapped ? sxs_pkg::RESP_OKAY : sxs_pkg::RESP_SLVERR;
      end
      else if (bready)
        bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cmd_r   <= sxs_pkg::RST_CMD;
      acc_r   <= sxs_pkg::RST_ACC;
      flags_r <= sxs_pkg::RST_FLAGS;
      dir_a_r <= sxs_pkg::RST_DIR;
      dir_b_r <= sxs_pkg::RST_DIR;
      dir_c_r <= sxs_pkg::RST_DIR;
    end
    else
    begin
      if (commit && w_cmd)
        cmd_r <= cmd_v;
      if (to_acc)
        acc_r <= result;
      else if (w_lane0 && w_acc)
        acc_r <= w_data_r[7:0];
      if (upd_cdz)
      begin
        flags_r.c  <= sub_sum[8];
        flags_r.dc <= nib_sum[4];
      end
      else if (w_lane0 && w_status)
      begin
        flags_r.c  <= w_data_r[0];
        flags_r.dc <= w_data_r[1];
      end
      if (upd_z)
        flags_r.z <= res_zero;
      else if (w_lane0 && w_status)
        flags_r.z <= w_data_r[2];
      if (do_halt)
      begin
        flags_r.halted            <= 1'b1;
        flags_r.power_down_flag_n <= 1'b0;
        flags_r.timeout_flag_n    <= 1'b1;
      end
      else if (w_lane0 && w_status && !w_data_r[5])
        flags_r.halted <= 1'b0;
      if (do_dir && cmd_v.f == sxs_pkg::SEL_DIR_A)
        dir_a_r <= acc_r;
      if (do_dir && cmd_v.f == sxs_pkg::SEL_DIR_B)
        dir_b_r <= acc_r;
      if (do_dir && cmd_v.f == sxs_pkg::SEL_DIR_C)
        dir_c_r <= acc_r;
    end
  end

  // Watchdog keeps its own time base, so it runs on during halt
  always_ff @(posedge aclk)
  begin
    if (!aresetn || do_halt)
    begin
      presc_r <= '0;
      wdog_r  <= sxs_pkg::WDOG_CLEAR;
    end
    else
    begin
      presc_r <= presc_r + 1'b1;
      if (&presc_r)
        wdog_r <= wdog_r + 8'h01;
    end
  end

  // File array reset costs area but gives tests a known start
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < sxs_pkg::FILE_DEPTH; i++)
        file_mem[i] <= sxs_pkg::RST_FILE;
    end
    else if (to_file)
      file_mem[cmd_v.f] <= result;
    else if (w_lane0 && w_file)
      file_mem[aw_addr_r[8:2]] <= w_data_r[7:0];
  end

  // Read path: one read at a time, answer one cycle after the address
  assign arready = !rvalid_r;
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;
  wire   r_aligned = (araddr[1:0] == 2'h0);
  wire   r_file    = r_aligned && (araddr[11:9] == sxs_pkg::FILE_PAGE);
  wire   r_cmd     = r_aligned && (araddr == sxs_pkg::OFF_CMD);
  wire   r_acc     = r_aligned && (araddr == sxs_pkg::OFF_ACC);
  wire   r_stat    = r_aligned && (araddr == sxs_pkg::OFF_STATUS);
  wire   r_dira    = r_aligned && (araddr == sxs_pkg::OFF_DIR_A);
  wire   r_dirb    = r_aligned && (araddr == sxs_pkg::OFF_DIR_B);
  wire   r_dirc    = r_aligned && (araddr == sxs_pkg::OFF_DIR_C);
  wire   r_wdog    = r_aligned && (araddr == sxs_pkg::OFF_WDOG);
  wire   r_mapped  = r_file || r_cmd || r_acc || r_stat || r_dira || r_dirb || r_dirc || r_wdog;
  wire [31:0] r_mux =
      r_cmd  ? cmd_r :
      r_acc  ? {24'h000000, acc_r} :
      r_stat ? {26'h0000000, flags_r} :
      r_dira ? {24'h000000, dir_a_r} :
      r_dirb ? {24'h000000, dir_b_r} :
      r_dirc ? {24'h000000, dir_c_r} :
      r_wdog ? {24'h000000, wdog_r} :
      r_file ? {24'h000000, file_mem[araddr[8:2]]} : 32'h0000_0000;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= sxs_pkg::RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid_r <= 1'b1;
      rdata_r  <= r_mux;
      rresp_r  <= r_mapped ? sxs_pkg::RESP_OKAY : sxs_pkg::RESP_SLVERR;
    end
    else if (rready)
      rvalid_r <= 1'b0;
  end

  assign osc_run          = !flags_r.halted;
  assign halted           = flags_r.halted;
  assign port_a_direction = dir_a_r;
  assign port_b_direction = dir_b_r;
  assign port_c_direction = dir_c_r;
  assign watchdog_counter = wdog_r;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  wire [7:0] lit_diff = lit_v - acc_r;
  wire [7:0] reg_diff = freg_v - acc_r;

  property p_lit_result;
    exec_go && op_lit |=> acc_r == $past(lit_diff);
  endproperty
  a_lit_result: assert property (p_lit_result) else $error("literal subtraction result wrong");
  property p_lit_carry;
    exec_go && op_lit |=> flags_r.c == ($past(acc_r) <= $past(lit_v));
  endproperty
  a_lit_carry: assert property (p_lit_carry) else $error("literal subtraction carry wrong");
  property p_lit_dc;
    exec_go && op_lit |=> flags_r.dc == ($past(acc_r[3:0]) <= $past(lit_v[3:0]));
  endproperty
  a_lit_dc: assert property (p_lit_dc) else $error("literal subtraction digit carry wrong");
  property p_halt_osc;
    exec_go && op_halt |=> !osc_run && halted;
  endproperty
  a_halt_osc: assert property (p_halt_osc) else $error("halt did not stop oscillator");
  property p_halt_wdog;
    exec_go && op_halt |=> watchdog_counter == 8'h00 && presc_r == '0;
  endproperty
  a_halt_wdog: assert property (p_halt_wdog) else $error("halt did not clear watchdog");
  property p_halt_flags;
    exec_go && op_halt |=> !flags_r.power_down_flag_n && flags_r.timeout_flag_n;
  endproperty
  a_halt_flags: assert property (p_halt_flags) else $error("halt status bits wrong");
  property p_reg_sub;
    exec_go && op_sub && !cmd_v.d |=> acc_r == $past(reg_diff);
  endproperty
  a_reg_sub: assert property (p_reg_sub) else $error("register subtraction result wrong");
  property p_dest_file;
    exec_go && is_reg && cmd_v.d |=> acc_r == $past(acc_r);
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("accumulator changed for file destination");
  property p_reg_carry;
    exec_go && op_sub |=> flags_r.c == ($past(acc_r) <= $past(freg_v));
  endproperty
  a_reg_carry: assert property (p_reg_carry) else $error("register subtraction carry wrong");
  property p_nib_flags;
    exec_go && (op_nib || op_dir) |=> $stable(flags_r);
  endproperty
  a_nib_flags: assert property (p_nib_flags) else $error("flags changed on flagless op");
  property p_xor_flags;
    exec_go && is_xor |=> $stable(flags_r.c) && $stable(flags_r.dc) && flags_r.z == ($past(xor_res) == 8'h00);
  endproperty
  a_xor_flags: assert property (p_xor_flags) else $error("xor flag update wrong");
  property p_dir_a;
    exec_go && op_dir && cmd_v.f == sxs_pkg::SEL_DIR_A |=> port_a_direction == $past(acc_r);
  endproperty
  a_dir_a: assert property (p_dir_a) else $error("direction A not loaded");
  property p_sub_zero;
    exec_go && is_sub |=> flags_r.z ==
      ((($past(cmd_v.d) && !$past(op_lit)) ? file_mem[$past(cmd_v.f)] : acc_r) == 8'h00);
  endproperty
  a_sub_zero: assert property (p_sub_zero) else $error("subtraction zero flag wrong");

  c_lit_sub:  cover property (exec_go && op_lit ##1 flags_r.z);
  c_subb:     cover property (exec_go && op_subb && !flags_r.c);
  c_halt_wake: cover property (do_halt ##[1:20] !halted);
  c_dir_c:    cover property (do_dir && cmd_v.f == sxs_pkg::SEL_DIR_C);

endmodule : sxs_exec

// ---- src/sxs_pkg.sv ----
/*
  Constants, opcodes and carrier types of the subtract, xor, swap and halt
  execution block.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package sxs_pkg;

  localparam int unsigned     ADDR_W      = 12;
  localparam int unsigned     DATA_W      = 32;
  localparam int unsigned     FILE_DEPTH  = 128;

  localparam logic [11:0]     OFF_CMD     = 12'h000;
  localparam logic [11:0]     OFF_ACC     = 12'h004;
  localparam logic [11:0]     OFF_STATUS  = 12'h008;
  localparam logic [11:0]     OFF_DIR_A   = 12'h00C;
  localparam logic [11:0]     OFF_DIR_B   = 12'h010;
  localparam logic [11:0]     OFF_DIR_C   = 12'h014;
  localparam logic [11:0]     OFF_WDOG    = 12'h018;
  localparam logic [2:0]      FILE_PAGE   = 3'h1;

  localparam logic [3:0]      OP_NOP          = 4'h0;
  localparam logic [3:0]      OP_LIT_SUB      = 4'h1;
  localparam logic [3:0]      OP_REG_SUB      = 4'h2;
  localparam logic [3:0]      OP_REG_SUB_B    = 4'h3;
  localparam logic [3:0]      OP_NIBBLE_EXCH  = 4'h4;
  localparam logic [3:0]      OP_XOR_LIT      = 4'h5;
  localparam logic [3:0]      OP_XOR_REG      = 4'h6;
  localparam logic [3:0]      OP_LOAD_DIR     = 4'h7;
  localparam logic [3:0]      OP_HALT         = 4'h8;

  localparam logic [6:0]      SEL_DIR_A   = 7'h05;
  localparam logic [6:0]      SEL_DIR_B   = 7'h06;
  localparam logic [6:0]      SEL_DIR_C   = 7'h07;

  localparam logic [7:0]      RST_ACC     = 8'h00;
  localparam logic [7:0]      RST_DIR     = 8'hFF;
  localparam logic [7:0]      RST_FILE    = 8'h00;
  localparam logic [7:0]      WDOG_CLEAR  = 8'h00;
  localparam logic [31:0]     RST_CMD     = 32'h0000_0000;

  localparam logic [1:0]      RESP_OKAY   = 2'h0;
  localparam logic [1:0]      RESP_SLVERR = 2'h2;

  // Command word: op [3:0], f [10:4], d [11], literal [23:16]
  typedef struct packed {
    logic [7:0] pad;
    logic [7:0] lit;
    logic [3:0] rsv;
    logic       d;
    logic [6:0] f;
    logic [3:0] op;
  } sxs_cmd_s;

  // Status word: carry [0], digit carry [1], zero [2], pd_n [3], to_n [4], halted [5]
  typedef struct packed {
    logic halted;
    logic timeout_flag_n;
    logic power_down_flag_n;
    logic z;
    logic dc;
    logic c;
  } sxs_flags_s;

  localparam sxs_flags_s      RST_FLAGS   = 6'h18;

endpackage : sxs_pkg

// ---- tb/testbench.sv ----
/*
  Self-checking bench for sxs_exec: drives the AXI4-Lite slave itself and
  checks results, flags, direction ports and halt behaviour.
  Assumes sxs_pkg and sxs_exec; prescaler shortened to 2 bits.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  localparam logic [1:0] OK = sxs_pkg::RESP_OKAY;
  localparam logic [1:0] ER = sxs_pkg::RESP_SLVERR;
  localparam logic [3:0] LS = sxs_pkg::OP_LIT_SUB;
  localparam logic [3:0] RS = sxs_pkg::OP_REG_SUB;
  localparam logic [3:0] RB = sxs_pkg::OP_REG_SUB_B;
  localparam logic [3:0] NX = sxs_pkg::OP_NIBBLE_EXCH;
  localparam logic [3:0] XL = sxs_pkg::OP_XOR_LIT;
  localparam logic [3:0] XR = sxs_pkg::OP_XOR_REG;
  logic        aclk;
  logic        aresetn;
  logic [11:0] awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic [11:0] araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        osc_run;
  logic        halted;
  logic [7:0]  port_a_direction;
  logic [7:0]  port_b_direction;
  logic [7:0]  port_c_direction;
  logic [7:0]  watchdog_counter;
  logic [31:0] v;
  logic [3:0]  wstrb;
  logic [3:0]  strb;
  logic        bready;
  logic        rready;
  int          n_fail;
  int          compares;

  // Protection unused; strobes follow strb
  sxs_exec #(.PRESC_W(2)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .osc_run(osc_run), .halted(halted), .port_a_direction(port_a_direction),
    .port_b_direction(port_b_direction), .port_c_direction(port_c_direction),
    .watchdog_counter(watchdog_counter)
  );

  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic test_done();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done

  // Only the watchdog ends a wait; bready is raised after the request and dropped on the answer
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    wstrb <= strb;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      bready <= !bvalid;
      if (bvalid)
        break;
    end
    `CHK(bresp, er)
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      rready <= !rvalid;
      if (rvalid)
        break;
    end
    v = rdata;
    `CHK(rresp, er)
  endtask : rd

  function automatic logic [11:0] fa(input logic [6:0] f);
    return 12'h200 + {3'h0, f, 2'h0};
  endfunction : fa

  task automatic ex(input logic [3:0] op, input logic [6:0] f, input logic d, input logic [7:0] lit);
    sxs_pkg::sxs_cmd_s c;
    c = '{pad: 8'h00, lit: lit, rsv: 4'h0, d: d, f: f, op: op};
    wr(sxs_pkg::OFF_CMD, c, OK);
  endtask : ex

  // Preloads state, runs one op, checks destination, the other operand and flags
  task automatic op_case(input logic [3:0] op, input logic [6:0] f, input logic d, input logic [7:0] lit,
                         input logic [7:0] acc0, input logic [7:0] fv, input logic [2:0] st0,
                         input logic [7:0] res, input logic [7:0] st1);
    wr(sxs_pkg::OFF_STATUS, {29'h0, st0}, OK);
    wr(sxs_pkg::OFF_ACC, {24'h0, acc0}, OK);
    wr(fa(f), {24'h0, fv}, OK);
    ex(op, f, d, lit);
    rd(d ? fa(f) : sxs_pkg::OFF_ACC, OK);
    `CHK(v, {24'h0, res})
    rd(d ? sxs_pkg::OFF_ACC : fa(f), OK);
    `CHK(v, {24'h0, (d ? acc0 : fv)})
    rd(sxs_pkg::OFF_STATUS, OK);
    `CHK(v, {24'h0, st1})
  endtask : op_case

  task automatic t_reset();
    rd(sxs_pkg::OFF_STATUS, OK);
    `CHK(v, 32'h00000018)
    `CHK({osc_run, halted, port_a_direction, port_b_direction, port_c_direction}, 26'h2FFFFFF)
  endtask : t_reset

  task automatic t_ops();
    op_case(LS, 7'h10, 1'b0, 8'h05, 8'h10, 8'h99, 3'h7, 8'hF5, 8'h1A);
    op_case(LS, 7'h10, 1'b0, 8'h33, 8'h33, 8'h99, 3'h0, 8'h00, 8'h1F);
    op_case(LS, 7'h10, 1'b0, 8'h10, 8'h0F, 8'h99, 3'h0, 8'h01, 8'h19);
    op_case(RS, 7'h7F, 1'b1, 8'h00, 8'h21, 8'h20, 3'h7, 8'hFF, 8'h18);
    op_case(RS, 7'h00, 1'b0, 8'h00, 8'h2C, 8'h4C, 3'h0, 8'h20, 8'h1B);
    op_case(RB, 7'h02, 1'b0, 8'h00, 8'h05, 8'h10, 3'h0, 8'h0A, 8'h19);
    op_case(RB, 7'h02, 1'b1, 8'h00, 8'h05, 8'h10, 3'h1, 8'h0B, 8'h19);
    op_case(RB, 7'h03, 1'b0, 8'h00, 8'h05, 8'h06, 3'h0, 8'h00, 8'h1F);
    op_case(RB, 7'h03, 1'b0, 8'h00, 8'h00, 8'h00, 3'h0, 8'hFF, 8'h18);
    op_case(NX, 7'h03, 1'b0, 8'h00, 8'h11, 8'hA5, 3'h5, 8'h5A, 8'h1D);
    op_case(NX, 7'h04, 1'b1, 8'h00, 8'h11, 8'h3C, 3'h2, 8'hC3, 8'h1A);
    op_case(XL, 7'h10, 1'b0, 8'h5A, 8'h5A, 8'h99, 3'h3, 8'h00, 8'h1F);
    op_case(XL, 7'h10, 1'b0, 8'h0F, 8'h5A, 8'h99, 3'h7, 8'h55, 8'h1B);
    op_case(XR, 7'h04, 1'b1, 8'h00, 8'hF0, 8'h0F, 3'h7, 8'hFF, 8'h1B);
    op_case(XR, 7'h05, 1'b0, 8'h00, 8'h3C, 8'h3C, 3'h0, 8'h00, 8'h1C);
  endtask : t_ops

  task automatic t_dir();
    wr(sxs_pkg::OFF_STATUS, 32'h00000005, OK);
    for (int i = 0; i < 3; i++)
    begin
      wr(sxs_pkg::OFF_ACC, 32'h000000A0 + 32'(i), OK);
      ex(sxs_pkg::OP_LOAD_DIR, sxs_pkg::SEL_DIR_A + 7'(i), 1'b0, 8'h00);
    end
    // Operand outside 5..7 and a write to a read-only copy must leave all three alone
    wr(sxs_pkg::OFF_ACC, 32'h00000077, OK);
    ex(sxs_pkg::OP_LOAD_DIR, 7'h08, 1'b0, 8'h00);
    wr(sxs_pkg::OFF_DIR_A, 32'h00000011, OK);
    `CHK({port_a_direction, port_b_direction, port_c_direction}, 24'hA0A1A2)
    rd(sxs_pkg::OFF_DIR_C, OK);
    `CHK(v, 32'h000000A2)
    rd(sxs_pkg::OFF_STATUS, OK);
    `CHK(v, 32'h0000001D)
  endtask : t_dir

  task automatic t_halt();
    wr(sxs_pkg::OFF_STATUS, 32'h00000002, OK);
    wr(sxs_pkg::OFF_ACC, 32'h00000044, OK);
    repeat (9) @(posedge aclk);
    ex(sxs_pkg::OP_HALT, 7'h00, 1'b0, 8'h00);
    `CHK(watchdog_counter, 8'h00)
    `CHK({halted, osc_run}, 2'b10)
    // Prescaler cleared too, so no tick can land two cycles later
    repeat (2) @(posedge aclk);
    `CHK(watchdog_counter, 8'h00)
    rd(sxs_pkg::OFF_STATUS, OK);
    `CHK(v, 32'h00000032)
    ex(XL, 7'h00, 1'b0, 8'h44);
    rd(sxs_pkg::OFF_ACC, OK);
    `CHK(v, 32'h00000044)
    wr(sxs_pkg::OFF_STATUS, 32'h00000000, OK);
    `CHK({halted, osc_run}, 2'b01)
  endtask : t_halt

  task automatic t_bad();
    wr(12'h01C, 32'h00000001, ER);
    wr(12'h006, 32'h00000001, ER);
    rd(12'h01C, ER);
    `CHK(v, 32'h00000000)
  endtask : t_bad

  // Lane 0 gates the 8-bit write, a zero strobe never executes, lanes merge into the command
  task automatic t_strb();
    wr(sxs_pkg::OFF_ACC, 32'h0000003C, OK);
    wr(sxs_pkg::OFF_CMD, 32'h00440000, OK);
    strb = 4'hE;
    wr(sxs_pkg::OFF_ACC, 32'h000000BB, OK);
    strb = 4'h0;
    wr(sxs_pkg::OFF_CMD, 32'h00FF0005, OK);
    strb = 4'h1;
    wr(sxs_pkg::OFF_CMD, 32'h00000005, OK);
    strb = 4'hF;
    rd(sxs_pkg::OFF_ACC, OK);
    `CHK(v, 32'h00000078)
  endtask : t_strb

  initial
  begin
    n_fail = 0;
    compares = 0;
    aresetn = 1'b0;
    awaddr = 12'h000;
    awvalid = 1'b0;
    wdata = 32'h00000000;
    wvalid = 1'b0;
    wstrb = 4'hF;
    strb = 4'hF;
    bready = 1'b0;
    rready = 1'b0;
    araddr = 12'h000;
    arvalid = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_ops();
    t_dir();
    t_halt();
    t_bad();
    t_strb();
    test_done();
  end

  // Whole run needs well under 4000 cycles
  initial
  begin
    repeat (4000) @(posedge aclk);
    n_fail++;
    test_done();
  end
endmodule : testbench
